// [verilog/srad_device.sv]
`timescale 1ns/10ps
// Summary of operation
// RQ1: host writes words zero to four first
// RQ2: words five to seven optional, defaults work
// RQ3: word three bits 20..23 govern words 4..7
// RQ4: default mode forces whole word to default
// RQ5: each optional word writable on its own
// RQ6: programmable word is sent over serial link
// RQ7: words 4..7 decoded by low address nibble
// RQ8: word four fixed bits held, fields placed
// RQ9: word four dither 2, order 3 defaults
// RQ10: aux polarity and prescaler default one
// RQ11: main pump polarity defaults to one
// RQ12: word five extended fraction defaults zero
// RQ13: word six slip, fastlock, timeout default zero
// RQ14: aux counter clear defaults to zero
// RQ15: main clear and pump hiz default zero
// RQ16: lock adjust zero, bits 11, 8 one
// RQ17: select field steers test/lock pin
// RQ18: auto power-up word zero clears aux powerdown
// RQ19: access bit one means programmable
module srad_device
    import srad_pkg::*;
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    srad_if.dev_mp                   bus,
    input  wire logic                i_main_lock,
    input  wire logic                i_aux_lock,
    output logic [WORD_W-1:0]        o_word0,
    output logic [WORD_W-1:0]        o_word1,
    output logic [WORD_W-1:0]        o_word2,
    output logic [WORD_W-1:0]        o_word3,
    output logic [WORD_W-1:0]        o_word4,
    output logic [WORD_W-1:0]        o_word5,
    output logic [WORD_W-1:0]        o_word6,
    output logic [WORD_W-1:0]        o_word7,
    output logic [ACCESS_W-1:0]      o_access,
    output logic [4:0]               o_base_written,
    output logic                     o_aux_loop_powerdown,
    output logic                     o_auto_power_up,
    output logic [TOS_W-1:0]         o_test_out_select,
    output logic                     o_test_lock_pin_o,
    output logic                     o_test_lock_pin_oe
);

    typedef struct packed {
        logic [SYNC_W-1:0]   sclk_sync;
        logic [SYNC_W-1:0]   data_sync;
        logic [SYNC_W-1:0]   latch_sync;
        logic                sclk_lvl;
        logic                data_lvl;
        logic                latch_lvl;
        logic [WORD_W-1:0]   shreg;
        logic [WORD_W-1:0]   w0;
        logic [WORD_W-1:0]   w1;
        logic [WORD_W-1:0]   w2;
        logic [WORD_W-1:0]   w3;
        logic [WORD_W-1:0]   prog4;
        logic [WORD_W-1:0]   prog5;
        logic [WORD_W-1:0]   prog6;
        logic [WORD_W-1:0]   prog7;
        logic [WORD_W-1:0]   eff4;
        logic [WORD_W-1:0]   eff5;
        logic [WORD_W-1:0]   eff6;
        logic [WORD_W-1:0]   eff7;
        logic [4:0]          written;
        logic                aux_pd;
        logic                pin_o;
        logic                pin_oe;
    } srad_dreg_type;

    srad_dreg_type        st_reg;
    srad_dreg_type        st_next;
    logic                 sclk_rise;
    logic                 latch_rise;
    logic [ADDR_W-1:0]    addr;
    logic [ACCESS_W-1:0]  access;
    logic [TOS_W-1:0]     tos;

    // filtered levels change only when the 2nd and 3rd stages agree
    assign sclk_rise  = (st_reg.sclk_sync[1] == st_reg.sclk_sync[2])
                        && st_reg.sclk_sync[2] && !st_reg.sclk_lvl;
    assign latch_rise = (st_reg.latch_sync[1] == st_reg.latch_sync[2])
                        && st_reg.latch_sync[2] && !st_reg.latch_lvl;
    assign addr       = st_reg.shreg[ADDR_W-1:0];
    assign access     = st_reg.w3[ACCESS_LSB +: ACCESS_W]; // see RQ3
    assign tos        = st_reg.eff4[W4_TOS_LSB +: TOS_W]; // see RQ8

    // next-state logic: synchronisers, shifter, word decode, defaults
    always_comb begin
        st_next = st_reg;

        // pins from the host pass three stages before use
        st_next.sclk_sync  = {st_reg.sclk_sync[1:0], bus.ser_clk};
        st_next.data_sync  = {st_reg.data_sync[1:0], bus.ser_data};
        st_next.latch_sync = {st_reg.latch_sync[1:0], bus.ser_latch};
        if (st_reg.sclk_sync[1] == st_reg.sclk_sync[2]) begin
            st_next.sclk_lvl = st_reg.sclk_sync[2];
        end
        if (st_reg.data_sync[1] == st_reg.data_sync[2]) begin
            st_next.data_lvl = st_reg.data_sync[2];
        end
        if (st_reg.latch_sync[1] == st_reg.latch_sync[2]) begin
            st_next.latch_lvl = st_reg.latch_sync[2];
        end

        // msb first; data settles before the clock rise is seen
        if (sclk_rise) begin
            st_next.shreg = {st_reg.shreg[WORD_W-2:0], st_reg.data_lvl};
        end

        // latch edge commits the word to the addressed slot
        if (latch_rise) begin
            if (!st_reg.shreg[W0_TAG_BIT]) begin
                st_next.w0         = st_reg.shreg;
                st_next.written[0] = 1'b1; // see RQ1
                if (st_reg.eff4[W4_AUTO_PU_BIT]) begin
                    st_next.aux_pd = 1'b0; // see RQ18
                end
            end else begin
                case (addr)
                    ADDR_W1: begin
                        st_next.w1         = st_reg.shreg;
                        st_next.written[1] = 1'b1;
                    end
                    ADDR_W2: begin
                        st_next.w2         = st_reg.shreg;
                        st_next.written[2] = 1'b1;
                        st_next.aux_pd     = st_reg.shreg[W2_AUX_PD_BIT];
                    end
                    ADDR_W3: begin
                        st_next.w3         = st_reg.shreg;
                        st_next.written[3] = 1'b1;
                    end
                    // each optional word stands alone; see RQ5 see RQ7
                    ADDR_W4: begin
                        st_next.prog4      = (st_reg.shreg & ~W4_FIXED_MASK)
                                             | W4_FIXED_VAL; // see RQ8
                        st_next.written[4] = 1'b1;
                    end
                    ADDR_W5: begin
                        st_next.prog5 = st_reg.shreg; // see RQ6
                    end
                    ADDR_W6: begin
                        st_next.prog6 = st_reg.shreg;
                    end
                    ADDR_W7: begin
                        st_next.prog7 = st_reg.shreg;
                    end
                    default: begin
                        st_next.w1 = st_reg.w1; // other codes are ignored
                    end
                endcase
            end
        end

        // effective words: access bit one takes the written value; see RQ19
        // zero forces the whole default word; see RQ4 see RQ2
        st_next.eff4 = access[ACC_W4] ? st_reg.prog4 : DEF_W4; // see RQ9 see RQ10 see RQ11
        st_next.eff5 = access[ACC_W5] ? st_reg.prog5 : DEF_W5; // see RQ12
        st_next.eff6 = access[ACC_W6] ? st_reg.prog6 : DEF_W6; // see RQ13
        st_next.eff7 = access[ACC_W7] ? st_reg.prog7 : DEF_W7; // see RQ14 see RQ15 see RQ16

        // test/lock pin steering; unused codes release the pin
        case (tos) // see RQ17
            TOS_DRIVE_HI: begin
                st_next.pin_o  = 1'b1;
                st_next.pin_oe = 1'b1;
            end
            TOS_DRIVE_LO: begin
                st_next.pin_o  = 1'b0;
                st_next.pin_oe = 1'b1;
            end
            TOS_BOTH_LOCK: begin
                st_next.pin_o  = i_main_lock & i_aux_lock;
                st_next.pin_oe = 1'b1;
            end
            TOS_MAIN_LOCK: begin
                st_next.pin_o  = i_main_lock;
                st_next.pin_oe = 1'b1;
            end
            default: begin
                st_next.pin_o  = 1'b0;
                st_next.pin_oe = 1'b0;
            end
        endcase
    end

    // never-written optional words still hold their defaults from reset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg       <= '0;
            st_reg.prog4 <= DEF_W4;
            st_reg.prog5 <= DEF_W5;
            st_reg.prog6 <= DEF_W6;
            st_reg.prog7 <= DEF_W7;
            st_reg.eff4  <= DEF_W4;
            st_reg.eff5  <= DEF_W5;
            st_reg.eff6  <= DEF_W6;
            st_reg.eff7  <= DEF_W7;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state
    assign o_word0              = st_reg.w0;
    assign o_word1              = st_reg.w1;
    assign o_word2              = st_reg.w2;
    assign o_word3              = st_reg.w3;
    assign o_word4              = st_reg.eff4;
    assign o_word5              = st_reg.eff5;
    assign o_word6              = st_reg.eff6;
    assign o_word7              = st_reg.eff7;
    assign o_access             = access;
    assign o_base_written       = st_reg.written;
    assign o_aux_loop_powerdown = st_reg.aux_pd;
    assign o_auto_power_up      = st_reg.eff4[W4_AUTO_PU_BIT];
    assign o_test_out_select    = tos;
    assign o_test_lock_pin_o    = st_reg.pin_o;
    assign o_test_lock_pin_oe   = st_reg.pin_oe;

endmodule

// [verilog/srad_pkg.sv]
package srad_pkg;

    // serial word layout
    localparam int WORD_W = 24;
    localparam int ADDR_W = 4;
    localparam int BITS_W = 5;

    // address codes carried in the low four bits of words one to seven
    localparam logic [ADDR_W-1:0] ADDR_W1 = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_W2 = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_W3 = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_W4 = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_W5 = 4'hB;
    localparam logic [ADDR_W-1:0] ADDR_W6 = 4'hD;
    localparam logic [ADDR_W-1:0] ADDR_W7 = 4'hF;
    localparam int W0_TAG_BIT = 0;

    // access bits of word three, one per optional word
    localparam int ACCESS_LSB = 20;
    localparam int ACCESS_W   = 4;
    localparam int ACC_W4     = 0;
    localparam int ACC_W5     = 1;
    localparam int ACC_W6     = 2;
    localparam int ACC_W7     = 3;

    // forced default contents of words four to seven
    localparam logic [WORD_W-1:0] DEF_W4 = 24'h02C709;
    localparam logic [WORD_W-1:0] DEF_W5 = 24'h00000B;
    localparam logic [WORD_W-1:0] DEF_W6 = 24'h00000D;
    localparam logic [WORD_W-1:0] DEF_W7 = 24'h00090F;

    // bits of word four that hold a fixed value when programmed
    localparam logic [WORD_W-1:0] W4_FIXED_MASK = 24'h7C2000;
    localparam logic [WORD_W-1:0] W4_FIXED_VAL  = 24'h200000;

    // field positions
    localparam int W2_AUX_PD_BIT   = 23;
    localparam int W4_AUTO_PU_BIT  = 23;
    localparam int W4_TOS_LSB      = 4;
    localparam int TOS_W           = 4;

    // test/lock pin selections
    localparam logic [TOS_W-1:0] TOS_HIZ       = 4'h0;
    localparam logic [TOS_W-1:0] TOS_DRIVE_HI  = 4'h1;
    localparam logic [TOS_W-1:0] TOS_DRIVE_LO  = 4'h2;
    localparam logic [TOS_W-1:0] TOS_BOTH_LOCK = 4'h3;
    localparam logic [TOS_W-1:0] TOS_MAIN_LOCK = 4'h4;

    // serial timing at a 25 ns system clock
    localparam int CLK_NS      = 25;
    localparam int SER_HALF_NS = 50;
    localparam int HALF_CYC    = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W      = 4;
    localparam int SYNC_W      = 3;

endpackage

// [verilog/srad_if.sv]
`timescale 1ns/10ps
interface srad_if;
    logic ser_clk;
    logic ser_data;
    logic ser_latch;

    modport host_mp (
        output ser_clk,
        output ser_data,
        output ser_latch
    );

    modport dev_mp (
        input  ser_clk,
        input  ser_data,
        input  ser_latch
    );
endinterface

// [verilog/srad_host.sv]
`timescale 1ns/10ps
module srad_host
    import srad_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    input  wire logic              i_start,
    input  wire logic [WORD_W-1:0] i_word,
    output logic                   o_ready,
    output logic                   o_done,
    srad_if.host_mp                bus
);

    typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_LATCH, HS_END} srad_hstate_type;

    typedef struct packed {
        srad_hstate_type    state;
        logic [TICK_W-1:0]  tick;
        logic [BITS_W-1:0]  bits;
        logic [WORD_W-1:0]  shreg;
        logic               sclk;
        logic               latch;
        logic               done;
    } srad_hreg_type;

    srad_hreg_type st_reg;
    srad_hreg_type st_next;
    logic          tick_en;

    // one-cycle enable per serial half period
    assign tick_en = (st_reg.tick == TICK_W'(HALF_CYC - 1));

    // the caller must supply words 0..4 and any word whose access bit is one; see RQ1 see RQ6
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (st_reg.state != HS_IDLE) begin
            st_next.tick = tick_en ? '0 : st_reg.tick + 1'b1;
        end
        case (st_reg.state)
            HS_IDLE: begin
                if (i_start) begin // any single optional word may be sent; see RQ5
                    st_next.state = HS_SHIFT;
                    st_next.shreg = i_word;
                    st_next.bits  = '0;
                    st_next.tick  = '0;
                end
            end
            HS_SHIFT: begin
                if (tick_en) begin
                    if (!st_reg.sclk) begin
                        st_next.sclk = 1'b1; // device samples on this rise
                    end else begin
                        st_next.sclk  = 1'b0;
                        st_next.shreg = {st_reg.shreg[WORD_W-2:0], 1'b0};
                        st_next.bits  = st_reg.bits + 1'b1;
                        if (st_reg.bits == BITS_W'(WORD_W - 1)) begin
                            st_next.state = HS_LATCH;
                        end
                    end
                end
            end
            HS_LATCH: begin
                if (tick_en) begin
                    st_next.latch = ~st_reg.latch;
                    if (st_reg.latch) begin
                        st_next.state = HS_END;
                    end
                end
            end
            HS_END: begin
                st_next.state = HS_IDLE;
                st_next.done  = 1'b1;
            end
            default: begin
                st_next.state = HS_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '{state: HS_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_ready       = (st_reg.state == HS_IDLE);
    assign o_done        = st_reg.done;
    assign bus.ser_clk   = st_reg.sclk;
    assign bus.ser_data  = st_reg.shreg[WORD_W-1];
    assign bus.ser_latch = st_reg.latch;

endmodule

// [dv/srad_sva.sv]
`timescale 1ns/10ps
module srad_sva
    import srad_pkg::*;
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    input  wire logic                ser_clk,
    input  wire logic                ser_latch,
    input  wire logic [WORD_W-1:0]   o_word3,
    input  wire logic [WORD_W-1:0]   o_word4,
    input  wire logic [WORD_W-1:0]   o_word5,
    input  wire logic [WORD_W-1:0]   o_word6,
    input  wire logic [WORD_W-1:0]   o_word7,
    input  wire logic [ACCESS_W-1:0] o_access,
    input  wire logic [4:0]          o_base_written,
    input  wire logic                o_auto_power_up,
    input  wire logic [TOS_W-1:0]    o_test_out_select,
    input  wire logic                o_test_lock_pin_o,
    input  wire logic                o_test_lock_pin_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // an access bit held two cycles, since the words follow word three one cycle late
    sequence s_held(logic b, logic v);
        (b == v) [*2];
    endsequence

    property p_access_map;   o_access == o_word3[23:20]; endproperty
    property p_w4_def;  s_held(o_access[ACC_W4], 1'b0) |-> o_word4 == DEF_W4; endproperty
    property p_w5_def;  s_held(o_access[ACC_W5], 1'b0) |-> o_word5 == DEF_W5; endproperty
    property p_w6_def;  s_held(o_access[ACC_W6], 1'b0) |-> o_word6 == DEF_W6; endproperty
    property p_w7_def;  s_held(o_access[ACC_W7], 1'b0) |-> o_word7 == DEF_W7; endproperty
    property p_w4_fixed;
        s_held(o_access[ACC_W4], 1'b1) |-> (o_word4 & W4_FIXED_MASK) == W4_FIXED_VAL;
    endproperty
    property p_fields;
        o_auto_power_up == o_word4[23] && o_test_out_select == o_word4[7:4];
    endproperty
    property p_pin_hi;
        $past(o_test_out_select) == TOS_DRIVE_HI |-> o_test_lock_pin_oe && o_test_lock_pin_o;
    endproperty
    property p_pin_hiz;  $past(o_test_out_select) == TOS_HIZ |-> !o_test_lock_pin_oe; endproperty
    // the serial clock must stay low while the word is latched
    property p_latch_quiet;  $rose(ser_latch) |-> !ser_clk [*2]; endproperty
    property p_written_sticky;  ($past(o_base_written) & ~o_base_written) == 5'h00; endproperty

    a_access_map: assert property (p_access_map) else $error("access bits misplaced");
    a_w4_def: assert property (p_w4_def) else $error("word four not default");
    a_w5_def: assert property (p_w5_def) else $error("word five not default");
    a_w6_def: assert property (p_w6_def) else $error("word six not default");
    a_w7_def: assert property (p_w7_def) else $error("word seven not default");
    a_w4_fixed: assert property (p_w4_fixed) else $error("word four fixed bits");
    a_fields: assert property (p_fields) else $error("word four fields");
    a_pin_hi: assert property (p_pin_hi) else $error("pin not driven high");
    a_pin_hiz: assert property (p_pin_hiz) else $error("pin driven in hiz");
    a_latch_quiet: assert property (p_latch_quiet) else $error("clock in latch");
    a_written_sticky: assert property (p_written_sticky) else $error("flag fell");
endmodule

// [dv/srad_tb_top.sv]
`timescale 1ns/10ps
module srad_tb_top;
    import srad_pkg::*;
    logic                i_clk_sys;
    logic                i_rst_n;
    logic                i_start;
    logic [WORD_W-1:0]   i_word;
    logic                o_ready;
    logic                o_done;
    logic                main_lock;
    logic                aux_lock;
    logic [WORD_W-1:0]   w [8];
    logic [ACCESS_W-1:0] acc;
    logic [4:0]          wr;
    logic                apu;
    logic                pd;
    logic [TOS_W-1:0]    tos;
    logic                pin_o;
    logic                pin_oe;
    int                  n_fail = 0;
    int                  compares = 0;
    int                  cyc = 0;

    srad_if u_srad_if ();
    srad_host u_srad_host (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start),
        .i_word(i_word), .o_ready(o_ready), .o_done(o_done), .bus(u_srad_if));
    srad_device u_srad_device (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .bus(u_srad_if),
        .i_main_lock(main_lock), .i_aux_lock(aux_lock), .o_word0(w[0]), .o_word1(w[1]),
        .o_word2(w[2]), .o_word3(w[3]), .o_word4(w[4]), .o_word5(w[5]), .o_word6(w[6]),
        .o_word7(w[7]), .o_access(acc), .o_base_written(wr), .o_aux_loop_powerdown(pd),
        .o_auto_power_up(apu), .o_test_out_select(tos), .o_test_lock_pin_o(pin_o),
        .o_test_lock_pin_oe(pin_oe));
    srad_sva u_srad_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .ser_clk(u_srad_if.ser_clk), .ser_latch(u_srad_if.ser_latch), .o_word3(w[3]),
        .o_word4(w[4]), .o_word5(w[5]), .o_word6(w[6]), .o_word7(w[7]), .o_access(acc),
        .o_base_written(wr), .o_auto_power_up(apu), .o_test_out_select(tos),
        .o_test_lock_pin_o(pin_o), .o_test_lock_pin_oe(pin_oe));

    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    // hang guard: the whole run needs about 3000 cycles
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one word through the host; waits for done, then for the device to commit
    task automatic send(input logic [WORD_W-1:0] v);
        int n;
        @(negedge i_clk_sys);
        chk("ready", 24'h1, {23'h0, o_ready});
        i_word = v;
        i_start = 1'b1;
        @(negedge i_clk_sys);
        chk("busy", 24'h0, {23'h0, o_ready});
        i_start = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 200) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n == 200) chk("done", 24'h1, 24'h0);
        repeat (6) @(negedge i_clk_sys);
    endtask

    task automatic t_reset();
        chk("word4", DEF_W4, w[4]);
        chk("word5", DEF_W5, w[5]);
        chk("word6", DEF_W6, w[6]);
        chk("word7", DEF_W7, w[7]);
        chk("pin_oe", 24'h0, {23'h0, pin_oe});
        chk("written", 24'h0, {19'h0, wr});
        chk("powerdown", 24'h0, {23'h0, pd});
        $display("test reset done");
    endtask

    // base words with every access bit clear: word four must stay default
    task automatic t_base();
        logic [WORD_W-1:0] v [5];
        v = '{24'h123450, 24'hABCDE3, 24'h000005, 24'h000007, 24'hFFFFF9};
        for (int i = 0; i < 5; i++) send(v[i]);
        for (int i = 0; i < 4; i++) chk("base word", v[i], w[i]);
        chk("written", 24'h00001F, {19'h0, wr});
        chk("word4 held", DEF_W4, w[4]);
        $display("test base done");
    endtask

    // each access bit alone selects its own word, the rest fall back to defaults
    task automatic t_access();
        logic [WORD_W-1:0] pg [4];
        logic [WORD_W-1:0] df [4];
        pg = '{(24'hFFFFF9 & ~W4_FIXED_MASK) | W4_FIXED_VAL, 24'h5A5A5B, 24'hC3C3CD, 24'h12345F};
        df = '{DEF_W4, DEF_W5, DEF_W6, DEF_W7};
        send(24'hF00007);
        send(24'hFFFFF9);
        for (int j = 1; j < 4; j++) send(pg[j]);
        for (int k = 0; k < 4; k++) begin
            send(24'h000007 | (24'h100000 << k));
            chk("access", 24'h1 << k, {20'h0, acc});
            for (int j = 0; j < 4; j++) chk("opt word", (j == k) ? pg[j] : df[j], w[j+4]);
        end
        send(24'hFFFFF1);
        chk("odd code", 24'hABCDE3, w[1]);
        chk("odd code", pg[3], w[7]);
        $display("test access done");
    endtask

    task automatic t_pin();
        logic [3:0] e;
        send(24'h100007);
        for (int s = 0; s < 5; s++) begin
            send(24'h000009 | (WORD_W'(s) << 4));
            e = 4'(s);
            chk("select", {20'h0, e}, {20'h0, tos});
            chk("pin_oe", {23'h0, s != 0}, {23'h0, pin_oe});
            if (s != 0) chk("pin_o", {23'h0, s == 1 || s == 4}, {23'h0, pin_o});
        end
        // the pin must follow the live lock level, not a copy taken at the write
        main_lock = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        chk("pin_o lock", 24'h0, {23'h0, pin_o});
        main_lock = 1'b1;
        $display("test pin done");
    endtask

    // word zero clears the aux powerdown only while auto power-up is set
    task automatic t_apu();
        send(24'h000009);
        send(24'h800005);
        send(24'h000000);
        chk("powerdown kept", 24'h1, {23'h0, pd});
        send(24'h800009);
        chk("auto_pu", 24'h1, {23'h0, apu});
        send(24'h000000);
        chk("powerdown clr", 24'h0, {23'h0, pd});
        $display("test auto power-up done");
    endtask

    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_start = 1'b0;
        i_word = 24'h000000;
        main_lock = 1'b1;
        aux_lock = 1'b0;
        repeat (10) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        t_reset();
        t_base();
        t_access();
        t_pin();
        t_apu();
        end_of_test();
    end
endmodule
